/* File: core/addr_map_core.sv */
/*
 * Program address generation and register file decode with storage for the
 * general-purpose, LCD and common areas; control locations go out on a port.
 * Assumes a synchronous ROM (data one cycle after address) and a control
 * block that answers ctrl_rdata combinationally in the cycle of ctrl_rd.
 */
// Behaviour
// RQ1 - Own 13-bit program address output
// RQ2 - Separate 8-bit register bus, address and data
// RQ3 - Program range 0FFFH or 1FFFH by variant
// RQ4 - Bytes 0000H-0001H flagged as interrupt vector
// RQ5 - Program counter starts at 0100H after reset
// RQ6 - Boot option bytes 3CH-3FH, default FFH
// RQ7 - 0002H-00FFH besides options is ordinary code
// RQ8 - 00H-BFH decode as general-purpose space
// RQ9 - Upper 64 locations are working and control
// RQ10 - 47 control locations forwarded on both pages
// RQ11 - 208 general-purpose bytes including common window
// RQ12 - Page 1 LCD bytes, plain storage when unused
// RQ13 - No extra pages over general-purpose range
// RQ14 - C0H-CFH same registers on every page
// RQ15 - Pairs even-aligned, high byte at even
// RQ16 - Stack lives in register file
// RQ17 - Push pre-decrements, pop post-increments pointer
// RQ18 - Stack pointer at D9H, reset value undefined
// RQ19 - Each access decodes to exactly one region
`timescale 1ns/1ps
module addr_map_core
    import addr_map_pkg::*;
#(
    parameter int PROG_KBYTES = PROG_KBYTES_DEF
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 lcd_en,
    input  wire logic                 page_sel,
    input  wire logic                 pc_load,
    input  wire logic [12:0]          pc_load_addr,
    input  wire logic                 pc_inc,
    input  wire logic [7:0]           rom_data,
    output logic      [12:0]          prog_addr,
    output logic                      fetch_valid,
    output prog_region_s              prog_region,
    output logic      [3:0][7:0]      boot_opt,
    input  wire logic                 rf_rd,
    input  wire logic                 rf_wr,
    input  wire logic                 rf_pair,
    input  wire logic [7:0]           rf_addr,
    input  wire logic [7:0]           rf_wdata,
    input  wire logic [15:0]          rf_wdata16,
    output logic                      rf_ready,
    output logic      [7:0]           rf_rdata,
    output logic      [15:0]          rf_rdata16,
    output logic                      rf_rvalid,
    output region_e                   rf_region,
    output logic                      rf_pair_err,
    output logic                      ctrl_wr,
    output logic                      ctrl_rd,
    output logic      [7:0]           ctrl_addr,
    output logic      [7:0]           ctrl_wdata,
    input  wire logic [7:0]           ctrl_rdata,
    input  wire logic                 stk_push,
    input  wire logic                 stk_pop,
    input  wire logic [7:0]           stk_wdata,
    output logic      [7:0]           stk_rdata,
    output logic                      stk_rvalid,
    output logic                      stk_fault,
    output logic      [7:0]           stack_top_pointer
);

    // RQ3 variant limit
    localparam logic [12:0] PROG_LIMIT = 13'((PROG_KBYTES * 1024) - 1);

    typedef struct packed {
        mode_e           mode;
        logic [2:0]      step;
        logic [12:0]     pc;
        logic [3:0][7:0] opt;
        logic [7:0]      rdata;
        logic [15:0]     rdata16;
        logic            rvalid;
        region_e         region;
        logic            pair_err;
        logic [7:0]      stk_rdata;
        logic            stk_rvalid;
        logic            stk_fault;
    } core_state_s;

    core_state_s s;
    core_state_s next_s;

    logic [7:0] gp_mem     [0:GP_BYTES-1];
    logic [7:0] lcd_mem    [0:LCD_BYTES-1];
    logic [7:0] common_mem [0:COMMON_BYTES-1];

    logic       take;
    logic       go;
    logic       bad_pair;
    logic       do_push;
    logic       do_pop;
    logic       stk_ok;
    logic       sp_wr;
    logic [7:0] a1;
    logic [7:0] stk_addr;
    region_e    reg0;
    region_e    reg1;
    logic [1:0] wr_en;
    logic [1:0][7:0] wr_addr;
    logic [1:0][7:0] wr_data;
    logic       wr_page;

    // ************************************************************
    // Register file read path
    // ************************************************************
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic pg);
        // RQ18 pointer lives at D9H
        if (a == SP_ADDR) return stack_top_pointer;
        if (a >= CTRL_LO) return ctrl_rdata;
        // RQ14 common window ignores page
        if (a >= COMMON_LO) return common_mem[a[3:0]];
        // RQ13 page 0 is the only general-purpose page
        if (!pg) return gp_mem[a];
        if (a <= LCD_HI) return lcd_mem[a[4:0]];
        return 8'h00;
    endfunction : rd_byte

    function automatic logic writable(input region_e r);
        return (r == RG_GP) || (r == RG_LCD) || (r == RG_COMMON);
    endfunction : writable

    stack_unit u_stack (
        .clk               (clk),
        .srst              (srst),
        .push              (do_push),
        .pop               (do_pop),
        .ptr_wr            (sp_wr),
        .ptr_wdata         (rf_wdata),
        .stack_top_pointer (stack_top_pointer),
        .op_addr           (stk_addr)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_s  = s;
        do_push = stk_push;
        do_pop  = stk_pop && !stk_push;
        // Stack traffic owns the array ports this cycle
        rf_ready = !(stk_push || stk_pop);
        // RQ2 register bus request
        take = (rf_rd || rf_wr) && rf_ready;
        a1   = rf_addr | BYTE_ONE;
        // RQ19 single region per address
        reg0 = region_of(rf_addr, page_sel, lcd_en);
        reg1 = region_of(a1, page_sel, lcd_en);
        // RQ15 even start, both halves in storage
        bad_pair = rf_pair && (rf_addr[0] || !writable(reg0) || !writable(reg1));
        go       = take && !bad_pair;
        // RQ10 control locations leave the block
        ctrl_wr    = go && rf_wr && !rf_pair && (reg0 == RG_CTRL) && (rf_addr != SP_ADDR);
        ctrl_rd    = go && rf_rd && !rf_pair && (reg0 == RG_CTRL) && (rf_addr != SP_ADDR);
        ctrl_addr  = rf_addr;
        ctrl_wdata = rf_wdata;
        // RQ18 software loads the pointer
        sp_wr  = go && rf_wr && !rf_pair && (rf_addr == SP_ADDR);
        // RQ16 stack confined to general-purpose bytes
        stk_ok = (stk_addr <= GP_HI);

        wr_page    = page_sel;
        wr_addr[0] = rf_addr;
        wr_addr[1] = a1;
        wr_data[0] = rf_pair ? rf_wdata16[15:8] : rf_wdata;
        wr_data[1] = rf_wdata16[7:0];
        wr_en[0]   = go && rf_wr && writable(reg0);
        wr_en[1]   = go && rf_wr && rf_pair;
        if (do_push) begin
            wr_page    = 1'b0;
            wr_addr[0] = stk_addr;
            wr_data[0] = stk_wdata;
            wr_en[0]   = stk_ok;
            wr_en[1]   = 1'b0;
        end

        next_s.rvalid   = go && rf_rd;
        next_s.pair_err = take && bad_pair;
        if (take) begin
            next_s.region = reg0;
        end
        if (go && rf_rd) begin
            next_s.rdata   = rd_byte(rf_addr, page_sel);
            // RQ15 high byte from even register
            next_s.rdata16 = rf_pair ? {rd_byte(rf_addr, page_sel), rd_byte(a1, page_sel)}
                                     : 16'h0000;
        end
        next_s.stk_rvalid = do_pop && stk_ok;
        next_s.stk_fault  = (do_push || do_pop) && !stk_ok;
        if (do_pop && stk_ok) begin
            next_s.stk_rdata = rd_byte(stk_addr, 1'b0);
        end

        // ************************************************************
        // Program side
        // ************************************************************
        unique case (s.mode)
            BOOT_READ: begin
                // RQ6 capture option bytes after reset
                if (s.step != 3'h0) begin
                    next_s.opt[2'(s.step - 3'h1)] = rom_data;
                end
                if (s.step == BOOT_STEPS) begin
                    next_s.mode = RUN;
                end else begin
                    next_s.step = s.step + 3'h1;
                end
            end
            RUN: begin
                if (pc_load) begin
                    next_s.pc = pc_load_addr;
                end else if (pc_inc) begin
                    next_s.pc = s.pc + 13'h0001;
                end
            end
        endcase
    end

    // ************************************************************
    // Storage and state registers
    // ************************************************************
    always_ff @(posedge clk) begin
        for (int l = 0; l < 2; l++) begin
            if (wr_en[l]) begin
                // RQ14 common window shared by all pages
                if (wr_addr[l] >= COMMON_LO) begin
                    common_mem[wr_addr[l][3:0]] <= wr_data[l];
                // RQ8 page 0 general-purpose bytes
                end else if (!wr_page) begin
                    gp_mem[wr_addr[l]] <= wr_data[l];
                // RQ12 LCD bytes keep data with driver off
                end else if (wr_addr[l] <= LCD_HI) begin
                    lcd_mem[wr_addr[l][4:0]] <= wr_data[l];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s.mode       <= BOOT_READ;
            s.step       <= 3'h0;
            // RQ5 reset entry
            s.pc         <= RESET_PC;
            s.opt        <= {BOOT_BYTES{BOOT_DEFAULT}};
            s.rdata      <= 8'h00;
            s.rdata16    <= 16'h0000;
            s.rvalid     <= 1'b0;
            s.region     <= RG_NONE;
            s.pair_err   <= 1'b0;
            s.stk_rdata  <= 8'h00;
            s.stk_rvalid <= 1'b0;
            s.stk_fault  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // RQ1 program address from its own bus
    assign fetch_valid = (s.mode == RUN);
    assign prog_addr   = (s.mode == BOOT_READ && s.step != BOOT_STEPS)
                       ? BOOT_LO + {10'h000, s.step} : s.pc;
    // RQ4 RQ7 RQ3 program region flags
    assign prog_region = prog_region_of(prog_addr, PROG_LIMIT);
    assign boot_opt    = s.opt;
    assign rf_rdata    = s.rdata;
    assign rf_rdata16  = s.rdata16;
    assign rf_rvalid   = s.rvalid;
    // RQ9 RQ11 region reported per access
    assign rf_region   = s.region;
    assign rf_pair_err = s.pair_err;
    assign stk_rdata   = s.stk_rdata;
    assign stk_rvalid  = s.stk_rvalid;
    assign stk_fault   = s.stk_fault;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // RQ5 pc held at entry
    pc_reset_hold_a: assert property (s.mode == BOOT_READ |-> s.pc == RESET_PC) // RQ5
        else $error("pc left reset entry during boot");
    // RQ6 boot read length
    boot_length_a: assert property ($fell(srst) |-> !fetch_valid [*5] ##1 fetch_valid) // RQ6
        else $error("boot option read not five cycles");
    // RQ18 pointer readable at D9H
    sp_read_a: assert property ((rf_rd && rf_ready && !rf_pair && rf_addr == SP_ADDR) // RQ18
        |=> rf_rvalid && rf_rdata == $past(stack_top_pointer))
        else $error("stack pointer read mismatch");
    // RQ15 odd pair refused
    pair_odd_a: assert property ((rf_pair && rf_addr[0] && (rf_rd || rf_wr) && rf_ready) // RQ15
        |=> rf_pair_err && !rf_rvalid)
        else $error("odd pair not refused");
    // RQ17 push decrement
    push_dec_a: assert property (stk_push // RQ17
        |=> stack_top_pointer == $past(stack_top_pointer) - BYTE_ONE)
        else $error("push did not decrement pointer");
    // RQ17 pop increment
    pop_inc_a: assert property ((stk_pop && !stk_push) // RQ17
        |=> stack_top_pointer == $past(stack_top_pointer) + BYTE_ONE)
        else $error("pop did not increment pointer");
    // RQ10 control strobe decode
    ctrl_decode_a: assert property ((ctrl_wr || ctrl_rd) // RQ10
        |-> rf_addr >= CTRL_LO && rf_addr != SP_ADDR && !ctrl_wr == rf_rd)
        else $error("control strobe outside control area");
    // RQ19 one region per access
    region_onehot_a: assert property (go // RQ19
        |=> (rf_region == RG_CTRL) == ($past(rf_addr) >= CTRL_LO))
        else $error("region decode mismatch");
    // RQ14 common window page-free
    common_window_a: assert property ((go && rf_addr >= COMMON_LO && rf_addr <= COMMON_HI) // RQ14
        |=> rf_region == RG_COMMON)
        else $error("common window depends on page");
    // RQ3 range flag
    prog_range_a: assert property ((prog_addr > PROG_LIMIT) |-> prog_region.beyond) // RQ3
        else $error("out of range fetch not flagged");

    boot_done_c: cover property ($fell(srst) ##6 fetch_valid);
    pair_read_c: cover property (rf_rd && rf_pair && rf_ready ##1 rf_rvalid);
    push_pop_c:  cover property (stk_push ##1 stk_pop ##1 stk_rvalid);
    lcd_access_c: cover property (go && page_sel && lcd_en && reg0 == RG_LCD);

endmodule : addr_map_core

/* File: core/addr_map_pkg.sv */
/*
 * Shared constants, region enumerations and decode helpers for the program
 * and register address map of the 8-bit core.
 * Assumes a single clock domain and an on-chip ROM with one cycle read latency.
 */
package addr_map_pkg;

    // ************************************************************
    // Program memory space
    // ************************************************************
    localparam int          PROG_AW         = 13;
    localparam int          PROG_KBYTES_DEF = 8;
    localparam logic [12:0] VECTOR_LO       = 13'h0000;
    localparam logic [12:0] VECTOR_HI       = 13'h0001;
    localparam logic [12:0] CODE_LO         = 13'h0002;
    localparam logic [12:0] CODE_HI         = 13'h00ff;
    localparam logic [12:0] BOOT_LO         = 13'h003c;
    localparam logic [12:0] BOOT_HI         = 13'h003f;
    localparam logic [12:0] RESET_PC        = 13'h0100;
    localparam logic [7:0]  BOOT_DEFAULT    = 8'hff;
    localparam int          BOOT_BYTES      = 4;
    localparam logic [2:0]  BOOT_STEPS      = 3'h4;

    // ************************************************************
    // Register file space
    // ************************************************************
    localparam int          RF_AW        = 8;
    localparam logic [7:0]  GP_HI        = 8'hbf;
    localparam logic [7:0]  LCD_HI       = 8'h12;
    localparam logic [7:0]  COMMON_LO    = 8'hc0;
    localparam logic [7:0]  COMMON_HI    = 8'hcf;
    localparam logic [7:0]  CTRL_LO      = 8'hd0;
    localparam logic [7:0]  SP_ADDR      = 8'hd9;
    localparam logic [7:0]  SP_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam int          GP_BYTES     = 192;
    localparam int          LCD_BYTES    = 19;
    localparam int          COMMON_BYTES = 16;

    typedef enum logic [2:0] {RG_NONE, RG_GP, RG_LCD, RG_COMMON, RG_CTRL} region_e;
    typedef enum logic {BOOT_READ, RUN} mode_e;

    typedef struct packed {
        logic vector;
        logic boot_opt;
        logic code;
        logic reset_entry;
        logic beyond;
    } prog_region_s;

    // Page only matters below the common window
    function automatic region_e region_of(input logic [7:0] a, input logic page,
                                          input logic lcd_en);
        if (a >= CTRL_LO) return RG_CTRL;
        if (a >= COMMON_LO) return RG_COMMON;
        if (!page) return RG_GP;
        if (a <= LCD_HI) return lcd_en ? RG_LCD : RG_GP;
        return RG_NONE;
    endfunction : region_of

    function automatic prog_region_s prog_region_of(input logic [12:0] a,
                                                    input logic [12:0] limit);
        prog_region_s r;
        r.vector      = (a <= VECTOR_HI);
        r.boot_opt    = (a >= BOOT_LO) && (a <= BOOT_HI);
        r.code        = (a >= CODE_LO) && (a <= CODE_HI) && !r.boot_opt;
        r.reset_entry = (a == RESET_PC);
        r.beyond      = (a > limit);
        return r;
    endfunction : prog_region_of

endpackage : addr_map_pkg

/* File: core/stack_unit.sv */
/*
 * Stack pointer register with pre-decrement push and post-increment pop.
 * Assumes the caller never asks for a pointer write in a stack cycle.
 */
`timescale 1ns/1ps
module stack_unit
    import addr_map_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic       ptr_wr,
    input  wire logic [7:0] ptr_wdata,
    output logic      [7:0] stack_top_pointer,
    output logic      [7:0] op_addr
);

    typedef struct packed {
        logic [7:0] ptr;
    } stack_state_s;

    stack_state_s s;
    stack_state_s next_s;

    always_comb begin
        next_s  = s;
        op_addr = s.ptr;
        // RQ17 push pre-decrements
        if (push) begin
            op_addr    = s.ptr - BYTE_ONE;
            next_s.ptr = s.ptr - BYTE_ONE;
        // RQ17 pop post-increments
        end else if (pop) begin
            next_s.ptr = s.ptr + BYTE_ONE;
        end else if (ptr_wr) begin
            next_s.ptr = ptr_wdata;
        end
    end

    // Pointer is undefined to software; zero keeps simulation clean
    always_ff @(posedge clk) begin
        if (srst) begin
            s.ptr <= SP_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign stack_top_pointer = s.ptr;

endmodule : stack_unit

/* File: tb/rom_ctrl_model.sv */
/*
 * Far side of the address map core: synchronous program ROM and a simple
 * control register block on the forwarded control strobes.
 * Assumes the core samples ctrl_rdata in the cycle of ctrl_rd.
 */
`timescale 1ns/1ps
module rom_ctrl_model (
    input  wire logic        clk,
    input  wire logic [12:0] prog_addr,
    output logic      [7:0]  rom_data,
    input  wire logic        ctrl_wr,
    input  wire logic        ctrl_rd,
    input  wire logic [7:0]  ctrl_addr,
    input  wire logic [7:0]  ctrl_wdata,
    output logic      [7:0]  ctrl_rdata
);
    logic [7:0] ctrl_mem [256];

    // ************************************************************
    // Program ROM
    // ************************************************************
    // option bytes content
    initial rom_data = 8'h00;
    always @(posedge clk) begin
        rom_data <= prog_addr[7:0] + 8'h5a;
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    initial begin
        for (int i = 0; i < 256; i++) begin
            ctrl_mem[i] = ~i[7:0];
        end
    end
    always @(posedge clk) begin
        if (ctrl_wr) begin
            ctrl_mem[ctrl_addr] <= ctrl_wdata;
        end
    end
    // Undriven bus shows inverted data so a stray sample is caught
    assign ctrl_rdata = ctrl_rd ? ctrl_mem[ctrl_addr] : ~ctrl_mem[ctrl_addr];
endmodule : rom_ctrl_model

/* File: tb/program_and_register_address_map_tb_top.sv */
/*
 * Self-checking bench for the address map core, small ROM variant.
 * Assumes the ROM and control block model of rom_ctrl_model.
 */
`timescale 1ns/1ps
module program_and_register_address_map_tb_top
    import addr_map_pkg::*;
;
    typedef struct packed {
        logic wr; logic pair; logic page; logic lcd;
        logic [7:0] addr; logic [15:0] d; region_e rg; logic err;
    } row_s;
    logic clk = 0, srst = 1, lcd_en = 0, page_sel = 0, pc_load = 0, pc_inc = 0;
    logic rf_rd = 0, rf_wr = 0, rf_pair = 0, stk_push = 0, stk_pop = 0;
    logic [12:0] pc_load_addr = 13'h0000, prog_addr;
    logic [7:0] rf_addr = 8'h00, rf_wdata = 8'h00, stk_wdata = 8'h00, rom_data;
    logic [7:0] rf_rdata, ctrl_addr, ctrl_wdata, ctrl_rdata, stk_rdata, stack_top_pointer;
    logic [15:0] rf_wdata16 = 16'h0000, rf_rdata16;
    logic fetch_valid, rf_ready, rf_rvalid, rf_pair_err, ctrl_wr, ctrl_rd, stk_rvalid, stk_fault;
    logic [3:0][7:0] boot_opt;
    prog_region_s prog_region;
    region_e rf_region;
    int errors = 0, checks = 0, n;
    row_s rows [24];

    always #5 clk = ~clk;

    addr_map_core #(.PROG_KBYTES(4)) uut (.clk(clk), .srst(srst), .lcd_en(lcd_en),
        .page_sel(page_sel), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .pc_inc(pc_inc),
        .rom_data(rom_data), .prog_addr(prog_addr), .fetch_valid(fetch_valid),
        .prog_region(prog_region), .boot_opt(boot_opt), .rf_rd(rf_rd), .rf_wr(rf_wr),
        .rf_pair(rf_pair), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_wdata16(rf_wdata16),
        .rf_ready(rf_ready), .rf_rdata(rf_rdata), .rf_rdata16(rf_rdata16),
        .rf_rvalid(rf_rvalid), .rf_region(rf_region), .rf_pair_err(rf_pair_err),
        .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata), .stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata),
        .stk_rdata(stk_rdata), .stk_rvalid(stk_rvalid), .stk_fault(stk_fault),
        .stack_top_pointer(stack_top_pointer));

    rom_ctrl_model model (.clk(clk), .prog_addr(prog_addr), .rom_data(rom_data),
        .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .ctrl_addr(ctrl_addr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // ************************************************************
    // Bus drivers
    // ************************************************************
    task automatic acc(input row_s r);
        logic ctl;
        @(posedge clk);
        rf_rd <= !r.wr; rf_wr <= r.wr; rf_pair <= r.pair; page_sel <= r.page;
        lcd_en <= r.lcd; rf_addr <= r.addr; rf_wdata <= r.d[7:0]; rf_wdata16 <= r.d;
        #1;
        ctl = !r.pair && r.addr >= 8'hd0 && r.addr != 8'hd9;
        chk({ctrl_wr, ctrl_rd}, {ctl && r.wr, ctl && !r.wr});
        @(posedge clk);
        rf_rd <= 0; rf_wr <= 0;
        #1;
        chk({rf_rvalid, rf_pair_err}, {!r.wr && !r.err, r.err});
        if (!r.err) chk(rf_region, r.rg);
        if (!r.wr && !r.err) chk(r.pair ? rf_rdata16 : {8'h00, rf_rdata}, r.d);
    endtask : acc

    task automatic stk(input logic push, input logic [7:0] d, input logic [7:0] exp_ptr,
                       input logic flt);
        @(posedge clk);
        stk_push <= push; stk_pop <= !push; stk_wdata <= d;
        rf_rd <= 1; rf_addr <= 8'h20; page_sel <= 0; rf_pair <= 0;
        #1;
        chk(rf_ready, 1'b0);
        @(posedge clk);
        stk_push <= 0; stk_pop <= 0; rf_rd <= 0;
        #1;
        chk(stack_top_pointer, exp_ptr);
        chk({stk_fault, stk_rvalid, rf_rvalid}, {flt, !push && !flt, 1'b0});
        if (!push && !flt) chk(stk_rdata, d);
    endtask : stk

    task automatic pc(input logic load, input logic [12:0] a, input prog_region_s f);
        @(posedge clk);
        pc_load <= load; pc_inc <= !load; pc_load_addr <= a;
        @(posedge clk);
        pc_load <= 0; pc_inc <= 0;
        #1;
        chk({prog_addr, prog_region}, {a, f});
    endtask : pc

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rows = '{
            '{1, 0, 0, 0, 8'h20, 16'h00a5, RG_GP, 0}, '{0, 0, 0, 0, 8'h20, 16'h00a5, RG_GP, 0},
            '{1, 0, 0, 0, 8'hbf, 16'h0042, RG_GP, 0}, '{0, 0, 0, 0, 8'hbf, 16'h0042, RG_GP, 0},
            '{1, 0, 1, 0, 8'hc4, 16'h003c, RG_COMMON, 0},
            '{0, 0, 0, 0, 8'hc4, 16'h003c, RG_COMMON, 0},
            '{1, 0, 0, 0, 8'h05, 16'h0011, RG_GP, 0}, '{1, 0, 1, 1, 8'h05, 16'h0077, RG_LCD, 0},
            '{0, 0, 1, 1, 8'h05, 16'h0077, RG_LCD, 0}, '{0, 0, 1, 0, 8'h05, 16'h0077, RG_GP, 0},
            '{0, 0, 0, 0, 8'h05, 16'h0011, RG_GP, 0}, '{1, 0, 1, 1, 8'h13, 16'h00ee, RG_NONE, 0},
            '{0, 0, 1, 1, 8'h13, 16'h0000, RG_NONE, 0}, '{1, 1, 0, 0, 8'h30, 16'h1234, RG_GP, 0},
            '{0, 0, 0, 0, 8'h30, 16'h0012, RG_GP, 0}, '{0, 0, 0, 0, 8'h31, 16'h0034, RG_GP, 0},
            '{0, 1, 0, 0, 8'h30, 16'h1234, RG_GP, 0}, '{1, 1, 0, 0, 8'h31, 16'habcd, RG_GP, 1},
            '{0, 0, 0, 0, 8'h31, 16'h0034, RG_GP, 0}, '{0, 1, 0, 0, 8'hd8, 16'h0000, RG_CTRL, 1},
            '{1, 0, 0, 0, 8'he0, 16'h005c, RG_CTRL, 0}, '{0, 0, 1, 0, 8'he0, 16'h005c, RG_CTRL, 0},
            '{0, 0, 0, 0, 8'hd0, 16'h002f, RG_CTRL, 0}, '{1, 0, 0, 0, 8'hd9, 16'h00c0, RG_CTRL, 0}};
        repeat (5) @(posedge clk);
        srst <= 0;
        #1;
        chk({prog_addr, fetch_valid, rf_region}, {13'h003c, 1'b0, RG_NONE});
        chk(boot_opt, 32'hffffffff);
        chk(stack_top_pointer, 8'h00);
        for (n = 1; n < 12; n++) begin
            @(posedge clk);
            #1;
            if (fetch_valid === 1'b1) break;
        end
        chk(n, 5);
        chk(boot_opt, 32'h99989796);
        chk({prog_addr, prog_region}, {13'h0100, 5'b00010});
        foreach (rows[i]) acc(rows[i]);
        chk(stack_top_pointer, 8'hc0);
        acc('{0, 0, 0, 0, 8'hd9, 16'h00c0, RG_CTRL, 0});
        stk(1, 8'h55, 8'hbf, 0);
        stk(1, 8'h66, 8'hbe, 0);
        acc('{0, 0, 1, 0, 8'hbe, 16'h0000, RG_NONE, 0});
        acc('{0, 0, 0, 0, 8'hbe, 16'h0066, RG_GP, 0});
        stk(0, 8'h66, 8'hbf, 0);
        stk(0, 8'h55, 8'hc0, 0);
        stk(0, 8'h00, 8'hc1, 1);
        stk(1, 8'h00, 8'hc0, 1);
        pc(1, 13'h0001, 5'b10000);
        pc(1, 13'h003d, 5'b01000);
        pc(1, 13'h0050, 5'b00100);
        pc(1, 13'h0100, 5'b00010);
        pc(1, 13'h0fff, 5'b00000);
        pc(0, 13'h1000, 5'b00001);
        results();
    end

    // Hang guard, run needs well under 400 cycles
    initial begin
        #20000;
        errors++;
        results();
    end
endmodule : program_and_register_address_map_tb_top
